/* File: verilog/rtc_pkg.sv */
`default_nettype none
package rtc_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_TRIM = 8'h01;
   localparam logic [7:0] ADDR_HOUR = 8'h04;
   localparam logic [7:0] ADDR_WEEKDAY = 8'h05;
   localparam logic [7:0] ADDR_DATE = 8'h06;
   localparam logic [7:0] ADDR_MONTH = 8'h07;
   localparam logic [7:0] ADDR_YEAR = 8'h08;
   localparam logic [7:0] ADDR_WDOG = 8'h09;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CENTURY_BIT = 6;
   localparam int CAL_MODE_BIT = 2;
   localparam int FREEZE_BIT = 1;
   localparam int SNAPSHOT_BIT = 0;
   localparam int OSC_DISABLE_BIT = 7;
   localparam int TRIM_SIGN_BIT = 5;
   localparam int WD_FLAG_BIT = 7;
   localparam int SUPPLY_FLAG_BIT = 6;
   localparam int LOW_BACKUP_BIT = 5;
   localparam logic [3:0] RESTART_KEY = 4'hA;

   // ------------------------------------------------------------
   // Field masks, BCD limits and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] HOUR_MASK = 8'h3F;
   localparam logic [7:0] WEEKDAY_MASK = 8'h07;
   localparam logic [7:0] DATE_MASK = 8'h3F;
   localparam logic [7:0] MONTH_MASK = 8'h1F;
   localparam logic [7:0] YEAR_MASK = 8'hFF;
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [7:0] HOUR_FIRST = 8'h00;
   localparam logic [7:0] HOUR_LAST = 8'h23;
   localparam logic [7:0] WEEKDAY_FIRST = 8'h01;
   localparam logic [7:0] WEEKDAY_LAST = 8'h07;
   localparam logic [7:0] DATE_FIRST = 8'h01;
   localparam logic [7:0] MONTH_FIRST = 8'h01;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_FIRST = 8'h00;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic OSC_DISABLE_RESET = 1'b1;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] weekday;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] year;
   } time_t;

   localparam time_t RESET_TIME = '{hour: HOUR_FIRST, weekday: WEEKDAY_FIRST,
      date: DATE_FIRST, month: MONTH_FIRST, year: YEAR_FIRST};

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic hour_tick;
      logic wd_reset;
      logic supply_reset;
      logic low_backup;
   } event_t;

   typedef struct packed {
      logic osc_disable;
      logic trim_sign;
      logic [4:0] trim_mag;
      logic cal_mode;
   } trim_t;
endpackage
`default_nettype wire

/* File: verilog/bcd_step.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// One BCD field step: first..last then back to first
// ------------------------------------------------------------
module bcd_step
(
   input wire logic [7:0] value, // Present BCD value
   input wire logic [7:0] first, // Value after wrap
   input wire logic [7:0] last, // Last value before wrap
   output logic [7:0] next_value, // Stepped value
   output logic wrap // High when last was reached
);
   // Units roll into tens at nine; a value past last (bad software write) also wraps
   always_comb
   begin
      wrap = (value >= last);
      if (wrap)
      begin
         next_value = first;
      end
      else if (value[3:0] >= rtc_pkg::BCD_NINE)
      begin
         next_value = {value[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         next_value = {value[7:4], value[3:0] + 4'h1};
      end
   end
endmodule // bcd_step
`default_nettype wire

/* File: verilog/rtc_regs.sv */
// Behaviour
// - Writing key 1010b to the restart field restarts the watchdog interval.
// - Any other key value leaves the watchdog alone; flags still update.
// - Watchdog and supply reset flags latch on their event until software clears.
// - Years hold two BCD digits, tens high nibble, range 0-99.
// - Month tens is bit 4, units bits 3:0, bits 7:5 read zero.
// - Date tens in bits 5:4, units bits 3:0, range 1-31.
// - Oscillator disable bit 7 stops timekeeping, reads 1 after reset.
// - Trim sign chooses adding or subtracting the trim amount.
// - Five-bit trim magnitude in bits 4:0, read and write.
// - Calibration mode bit 2: 1 enters calibration, 0 returns to normal.
// - Outside calibration mode the shared pin carries the comparator result.
// - Snapshot 0 to 1 copies the running core into the user registers.
// - Flags register: century bit 6, cal bit 2, freeze bit 1, snapshot bit 0.
`timescale 1ns/1ns
`default_nettype none
module rtc_regs
(
   input wire logic clk, // 125 MHz clock
   input wire logic nrst, // Synchronous reset, active low
   input wire rtc_pkg::reg_req_t req, // Register read and write strobes
   input wire rtc_pkg::event_t events, // Hour carry and reset source pulses
   input wire logic cal_clock, // Calibration clock from oscillator
   input wire logic compare_in, // Voltage comparator result
   output logic [7:0] rdata, // Read data, valid cycle after rd
   output rtc_pkg::trim_t trim, // Oscillator and trim controls
   output logic wd_restart, // One-cycle watchdog restart pulse
   output logic trim_or_compare_out // Shared calibration/compare pin
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      rtc_pkg::time_t core;
      rtc_pkg::time_t user;
      logic century;
      logic freeze;
      logic snapshot;
      rtc_pkg::trim_t trim;
      logic wd_flag;
      logic supply_flag;
      logic low_backup;
      logic wd_restart;
      logic [7:0] rdata;
   } state_t;

   state_t s;
   state_t next_s;

   logic [7:0] hour_next, weekday_next, date_next, month_next, year_next;
   logic hour_wrap, weekday_wrap, date_wrap, month_wrap, year_wrap;
   logic [7:0] date_last;
   logic tick;
   logic wr_flags, wr_trim, wr_wdog, wr_time;
   logic [7:0] read_mux;

   // Last day of the month; leap test covers 00-99 only, which matches the years range
   function automatic logic [7:0] month_last_day(input logic [7:0] month,
                                                 input logic [7:0] year);
      logic leap;
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
      case (month)
         8'h02: month_last_day = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
         8'h04, 8'h06, 8'h09, 8'h11: month_last_day = rtc_pkg::DAYS_30;
         default: month_last_day = rtc_pkg::DAYS_31;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Calendar steppers
   // ------------------------------------------------------------
   assign date_last = month_last_day(s.core.month, s.core.year);

   bcd_step hour_step (.value(s.core.hour), .first(rtc_pkg::HOUR_FIRST),
      .last(rtc_pkg::HOUR_LAST), .next_value(hour_next), .wrap(hour_wrap));
   bcd_step weekday_step (.value(s.core.weekday), .first(rtc_pkg::WEEKDAY_FIRST),
      .last(rtc_pkg::WEEKDAY_LAST), .next_value(weekday_next), .wrap(weekday_wrap));
   bcd_step date_step (.value(s.core.date), .first(rtc_pkg::DATE_FIRST),
      .last(date_last), .next_value(date_next), .wrap(date_wrap));
   bcd_step month_step (.value(s.core.month), .first(rtc_pkg::MONTH_FIRST),
      .last(rtc_pkg::MONTH_LAST), .next_value(month_next), .wrap(month_wrap));
   bcd_step year_step (.value(s.core.year), .first(rtc_pkg::YEAR_FIRST),
      .last(rtc_pkg::YEAR_LAST), .next_value(year_next), .wrap(year_wrap));

   // Stopped oscillator means no carries reach the calendar
   assign tick = events.hour_tick && !s.trim.osc_disable;

   // Address decode
   assign wr_flags = req.wr && (req.addr == rtc_pkg::ADDR_FLAGS);
   assign wr_trim = req.wr && (req.addr == rtc_pkg::ADDR_TRIM);
   assign wr_wdog = req.wr && (req.addr == rtc_pkg::ADDR_WDOG);
   assign wr_time = req.wr && (req.addr == rtc_pkg::ADDR_HOUR ||
      req.addr == rtc_pkg::ADDR_WEEKDAY || req.addr == rtc_pkg::ADDR_DATE ||
      req.addr == rtc_pkg::ADDR_MONTH || req.addr == rtc_pkg::ADDR_YEAR);

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   // Restart key is write-only and reserved bits read zero; unmapped reads zero
   always_comb
   begin
      read_mux = 8'h00;
      case (req.addr)
         rtc_pkg::ADDR_FLAGS:
         begin
            read_mux[rtc_pkg::CENTURY_BIT] = s.century;
            read_mux[rtc_pkg::CAL_MODE_BIT] = s.trim.cal_mode;
            read_mux[rtc_pkg::FREEZE_BIT] = s.freeze;
            read_mux[rtc_pkg::SNAPSHOT_BIT] = s.snapshot;
         end
         rtc_pkg::ADDR_TRIM:
         begin
            read_mux[rtc_pkg::OSC_DISABLE_BIT] = s.trim.osc_disable;
            read_mux[rtc_pkg::TRIM_SIGN_BIT] = s.trim.trim_sign;
            read_mux[4:0] = s.trim.trim_mag;
         end
         rtc_pkg::ADDR_HOUR: read_mux = s.user.hour & rtc_pkg::HOUR_MASK;
         rtc_pkg::ADDR_WEEKDAY: read_mux = s.user.weekday & rtc_pkg::WEEKDAY_MASK;
         rtc_pkg::ADDR_DATE: read_mux = s.user.date & rtc_pkg::DATE_MASK;
         rtc_pkg::ADDR_MONTH: read_mux = s.user.month & rtc_pkg::MONTH_MASK;
         rtc_pkg::ADDR_YEAR: read_mux = s.user.year & rtc_pkg::YEAR_MASK;
         rtc_pkg::ADDR_WDOG:
         begin
            read_mux[rtc_pkg::WD_FLAG_BIT] = s.wd_flag;
            read_mux[rtc_pkg::SUPPLY_FLAG_BIT] = s.supply_flag;
            read_mux[rtc_pkg::LOW_BACKUP_BIT] = s.low_backup;
         end
         default: read_mux = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.wd_restart = 1'b0;
      if (req.rd)
      begin
         next_s.rdata = read_mux;
      end

      // Running core; carries ripple only on the wrap of the field below
      if (tick)
      begin
         next_s.core.hour = hour_next;
         if (hour_wrap)
         begin
            next_s.core.weekday = weekday_next;
            next_s.core.date = date_next;
            if (date_wrap)
            begin
               next_s.core.month = month_next;
               if (month_wrap)
               begin
                  next_s.core.year = year_next;
               end
            end
         end
      end

      // User copy follows the core only while neither held nor captured
      if (!s.freeze && !s.snapshot)
      begin
         next_s.user = s.core;
      end

      // Flags register; century is set-wins against a software clear
      if (wr_flags)
      begin
         next_s.century = req.wdata[rtc_pkg::CENTURY_BIT];
         next_s.trim.cal_mode = req.wdata[rtc_pkg::CAL_MODE_BIT];
         next_s.freeze = req.wdata[rtc_pkg::FREEZE_BIT];
         next_s.snapshot = req.wdata[rtc_pkg::SNAPSHOT_BIT];
         if (req.wdata[rtc_pkg::SNAPSHOT_BIT] && !s.snapshot)
         begin
            next_s.user = s.core;
         end
         if (!req.wdata[rtc_pkg::FREEZE_BIT] && s.freeze)
         begin
            next_s.core = s.user;
         end
      end
      if (tick && hour_wrap && date_wrap && month_wrap && year_wrap)
      begin
         next_s.century = 1'b1;
      end

      // Oscillator and trim
      if (wr_trim)
      begin
         next_s.trim.osc_disable = req.wdata[rtc_pkg::OSC_DISABLE_BIT];
         next_s.trim.trim_sign = req.wdata[rtc_pkg::TRIM_SIGN_BIT];
         next_s.trim.trim_mag = req.wdata[4:0];
      end

      // User time writes land only while frozen, else the tracking copy would undo them
      if (wr_time && s.freeze)
      begin
         case (req.addr)
            rtc_pkg::ADDR_HOUR: next_s.user.hour = req.wdata & rtc_pkg::HOUR_MASK;
            rtc_pkg::ADDR_WEEKDAY: next_s.user.weekday = req.wdata & rtc_pkg::WEEKDAY_MASK;
            rtc_pkg::ADDR_DATE: next_s.user.date = req.wdata & rtc_pkg::DATE_MASK;
            rtc_pkg::ADDR_MONTH: next_s.user.month = req.wdata & rtc_pkg::MONTH_MASK;
            default: next_s.user.year = req.wdata & rtc_pkg::YEAR_MASK;
         endcase
      end

      // Watchdog restart and reset-source flags
      if (wr_wdog)
      begin
         next_s.wd_flag = req.wdata[rtc_pkg::WD_FLAG_BIT];
         next_s.supply_flag = req.wdata[rtc_pkg::SUPPLY_FLAG_BIT];
         next_s.low_backup = req.wdata[rtc_pkg::LOW_BACKUP_BIT];
         if (req.wdata[3:0] == rtc_pkg::RESTART_KEY)
         begin
            next_s.wd_restart = 1'b1;
         end
      end
      // Events after the write so a set in the clearing cycle is kept
      if (events.wd_reset)
      begin
         next_s.wd_flag = 1'b1;
      end
      if (events.supply_reset)
      begin
         next_s.supply_flag = 1'b1;
      end
      if (events.low_backup)
      begin
         next_s.low_backup = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.core <= rtc_pkg::RESET_TIME;
         s.user <= rtc_pkg::RESET_TIME;
         s.trim.osc_disable <= rtc_pkg::OSC_DISABLE_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs
   assign rdata = s.rdata;
   assign trim = s.trim;
   assign wd_restart = s.wd_restart;
   // Pin mux is combinational so the calibration clock passes without a flop delay
   assign trim_or_compare_out = s.trim.cal_mode ? cal_clock : compare_in;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   restart_key_a: assert property (wr_wdog && req.wdata[3:0] == rtc_pkg::RESTART_KEY
      |=> wd_restart ##1 !wd_restart) else $error("restart key missed");
   restart_other_a: assert property (!(wr_wdog && req.wdata[3:0] == rtc_pkg::RESTART_KEY)
      |=> !wd_restart) else $error("spurious restart");
   wd_flag_set_a: assert property (events.wd_reset |=> s.wd_flag)
      else $error("watchdog flag lost");
   supply_flag_hold_a: assert property (s.supply_flag && !wr_wdog |=> s.supply_flag)
      else $error("supply flag dropped");
   hour_read_a: assert property (req.rd && req.addr == rtc_pkg::ADDR_HOUR
      |=> rdata[7:6] == 2'b00) else $error("hour top bits set");
   month_read_a: assert property (req.rd && req.addr == rtc_pkg::ADDR_MONTH
      |=> rdata[7:5] == 3'b000) else $error("month top bits set");
   osc_stop_a: assert property (s.trim.osc_disable && !wr_flags |=> $stable(s.core))
      else $error("core ran while stopped");
   weekday_ring_a: assert property (tick && hour_wrap
      && s.core.weekday == rtc_pkg::WEEKDAY_LAST |=> s.core.weekday == rtc_pkg::WEEKDAY_FIRST)
      else $error("weekday ring broken");
   century_set_a: assert property (tick && hour_wrap && date_wrap && month_wrap && year_wrap
      |=> s.century && s.core.year == rtc_pkg::YEAR_FIRST) else $error("century missed");
   freeze_hold_a: assert property (s.freeze && !wr_time && !wr_flags |=> $stable(s.user))
      else $error("user time moved while frozen");
   snapshot_copy_a: assert property (wr_flags && req.wdata[rtc_pkg::SNAPSHOT_BIT]
      && !s.snapshot |=> s.user == $past(s.core)) else $error("snapshot not copied");
   freeze_load_a: assert property (wr_flags && !req.wdata[rtc_pkg::FREEZE_BIT] && s.freeze
      |=> s.core == $past(s.user)) else $error("freeze release no load");
   compare_pin_a: assert property (!s.trim.cal_mode |-> trim_or_compare_out == compare_in)
      else $error("pin not on comparator");

   year_roll_c: cover property (tick && year_wrap && month_wrap && date_wrap && hour_wrap);
   freeze_cycle_c: cover property (s.freeze ##[1:20] !s.freeze);
   restart_c: cover property (wd_restart);
   leap_day_c: cover property (tick && hour_wrap && date_last == rtc_pkg::DAYS_29);
endmodule // rtc_regs
`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module host_model
(
   input wire logic clk, // System clock
   input wire logic go, // Request held for one cycle
   input wire rtc_pkg::reg_req_t cmd, // Request to place on the port
   output rtc_pkg::reg_req_t req // Port toward the device
);
   logic [15:0] last = 16'h0000;

   // Remember what was last driven, so a released port can show its inverse
   always_ff @(posedge clk)
   begin
      if (go)
      begin
         last <= {cmd.addr, cmd.wdata};
      end
   end

   // Released lines never repeat stale data that a careless decoder could reuse
   always_comb
   begin
      req = go ? cmd : {2'b00, ~last};
   end
endmodule // host_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic go = 1'b0;
   rtc_pkg::reg_req_t cmd = '0;
   rtc_pkg::reg_req_t req;
   logic [3:0] events = 4'h0;
   logic cal_clock = 1'b0;
   logic compare_in = 1'b0;
   logic [7:0] rdata;
   rtc_pkg::trim_t trim;
   logic wd_restart;
   logic trim_or_compare_out;
   logic p;
   int bad_count = 0;
   int n_compared = 0;
   logic [39:0] tbl [5] = '{40'h28_0224_2902, 40'h28_0223_0103, 40'h29_0224_0103,
      40'h30_0423_0105, 40'h30_0523_3105};

   // ------------------------------------------------------------
   // Clock, host and device
   // ------------------------------------------------------------
   always #4 clk = ~clk;
   host_model host (.clk(clk), .go(go), .cmd(cmd), .req(req));
   rtc_regs dut (.clk(clk), .nrst(nrst), .req(req), .events(events), .cal_clock(cal_clock),
      .compare_in(compare_in), .rdata(rdata), .trim(trim), .wd_restart(wd_restart),
      .trim_or_compare_out(trim_or_compare_out));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One request; an idle cycle follows so go never changes twice in a step
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic pulse);
      cmd = '{rd: ~w, wr: w, addr: a, wdata: d};
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      pulse = wd_restart;
      @(negedge clk);
      check("restart_width", {7'h00, wd_restart}, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d, p);
   endtask

   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00, p);
      check(n, rdata, e);
   endtask

   // Event pulse of one cycle, then time for the user copy to follow
   task automatic pulse_event(input logic [3:0] e);
      events = e;
      @(negedge clk);
      events = 4'h0;
      repeat (2) @(negedge clk);
   endtask

   task automatic set_time(input logic [7:0] h, d, m, y);
      wr(rtc_pkg::ADDR_FLAGS, 8'h02);
      wr(rtc_pkg::ADDR_HOUR, h);
      wr(rtc_pkg::ADDR_WEEKDAY, 8'h03);
      wr(rtc_pkg::ADDR_DATE, d);
      wr(rtc_pkg::ADDR_MONTH, m);
      wr(rtc_pkg::ADDR_YEAR, y);
      wr(rtc_pkg::ADDR_FLAGS, 8'h00);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      check("trim_port", trim, 8'h80);
      rd("flags", rtc_pkg::ADDR_FLAGS, 8'h00);
      rd("trim", rtc_pkg::ADDR_TRIM, 8'h80);
      rd("hour", rtc_pkg::ADDR_HOUR, 8'h00);
      rd("weekday", rtc_pkg::ADDR_WEEKDAY, 8'h01);
      rd("date", rtc_pkg::ADDR_DATE, 8'h01);
      rd("month", rtc_pkg::ADDR_MONTH, 8'h01);
      rd("year", rtc_pkg::ADDR_YEAR, 8'h00);
      rd("wdog", rtc_pkg::ADDR_WDOG, 8'h00);
      wr(8'h02, 8'h55);
      rd("unmapped", 8'h02, 8'h00);
   endtask

   // Stopped oscillator must swallow the hour carry
   task automatic t_trim;
      wr(rtc_pkg::ADDR_TRIM, 8'h7F);
      rd("trim_rd", rtc_pkg::ADDR_TRIM, 8'h3F);
      check("trim_port", trim, 8'h7E);
      pulse_event(4'h8);
      rd("hour_run", rtc_pkg::ADDR_HOUR, 8'h01);
      wr(rtc_pkg::ADDR_TRIM, 8'h85);
      check("trim_port", trim, 8'h8A);
      pulse_event(4'h8);
      rd("hour_stop", rtc_pkg::ADDR_HOUR, 8'h01);
      wr(rtc_pkg::ADDR_TRIM, 8'h00);
   endtask

   task automatic t_pin;
      for (int i = 0; i < 2; i++)
      begin
         compare_in = i[0];
         cal_clock = ~i[0];
         @(negedge clk);
         check("pin_cmp", {7'h00, trim_or_compare_out}, {7'h00, i[0]});
      end
      wr(rtc_pkg::ADDR_FLAGS, 8'h04);
      rd("flags_cal", rtc_pkg::ADDR_FLAGS, 8'h04);
      check("pin_cal", {7'h00, trim_or_compare_out}, {7'h00, cal_clock});
      wr(rtc_pkg::ADDR_FLAGS, 8'h00);
   endtask

   task automatic t_wdog;
      access(1'b1, rtc_pkg::ADDR_WDOG, 8'hEA, p);
      check("restart", {7'h00, p}, 8'h01);
      rd("wdog_flags", rtc_pkg::ADDR_WDOG, 8'hE0);
      for (int k = 0; k < 16; k++)
      begin
         if (k != 10)
         begin
            access(1'b1, rtc_pkg::ADDR_WDOG, {4'h0, k[3:0]}, p);
            check("no_restart", {7'h00, p}, 8'h00);
         end
      end
      rd("wdog_clear", rtc_pkg::ADDR_WDOG, 8'h00);
      pulse_event(4'h6);
      rd("both_flags", rtc_pkg::ADDR_WDOG, 8'hC0);
      pulse_event(4'h0);
      rd("flags_stay", rtc_pkg::ADDR_WDOG, 8'hC0);
      wr(rtc_pkg::ADDR_WDOG, 8'h00);
   endtask

   // Full rollover; a carry seen while frozen must be lost at release
   task automatic t_rollover;
      set_time(8'h23, 8'h31, 8'h12, 8'h99);
      wr(rtc_pkg::ADDR_FLAGS, 8'h02);
      wr(rtc_pkg::ADDR_WEEKDAY, 8'h07);
      pulse_event(4'h8);
      rd("frozen", rtc_pkg::ADDR_HOUR, 8'h23);
      wr(rtc_pkg::ADDR_FLAGS, 8'h00);
      rd("loaded", rtc_pkg::ADDR_HOUR, 8'h23);
      pulse_event(4'h8);
      rd("hour", rtc_pkg::ADDR_HOUR, 8'h00);
      rd("weekday", rtc_pkg::ADDR_WEEKDAY, 8'h01);
      rd("date", rtc_pkg::ADDR_DATE, 8'h01);
      rd("month", rtc_pkg::ADDR_MONTH, 8'h01);
      rd("year", rtc_pkg::ADDR_YEAR, 8'h00);
      rd("century", rtc_pkg::ADDR_FLAGS, 8'h40);
      wr(rtc_pkg::ADDR_FLAGS, 8'h00);
   endtask

   task automatic t_calendar;
      foreach (tbl[i])
      begin
         set_time(8'h23, tbl[i][39:32], tbl[i][31:24], tbl[i][23:16]);
         pulse_event(4'h8);
         rd("weekday", rtc_pkg::ADDR_WEEKDAY, 8'h04);
         rd("date", rtc_pkg::ADDR_DATE, tbl[i][15:8]);
         rd("month", rtc_pkg::ADDR_MONTH, tbl[i][7:0]);
      end
   endtask

   // Only a rising snapshot bit may refresh the held image
   task automatic t_snapshot;
      wr(rtc_pkg::ADDR_FLAGS, 8'h01);
      pulse_event(4'h8);
      wr(rtc_pkg::ADDR_FLAGS, 8'h01);
      rd("held", rtc_pkg::ADDR_HOUR, 8'h00);
      wr(rtc_pkg::ADDR_FLAGS, 8'h00);
      wr(rtc_pkg::ADDR_FLAGS, 8'h01);
      rd("captured", rtc_pkg::ADDR_HOUR, 8'h01);
   endtask

   task automatic t_reserved;
      wr(rtc_pkg::ADDR_FLAGS, 8'h02);
      wr(rtc_pkg::ADDR_HOUR, 8'hFF);
      rd("hour_mask", rtc_pkg::ADDR_HOUR, 8'h3F);
      wr(rtc_pkg::ADDR_DATE, 8'hFF);
      rd("date_mask", rtc_pkg::ADDR_DATE, 8'h3F);
      wr(rtc_pkg::ADDR_MONTH, 8'hFF);
      rd("month_mask", rtc_pkg::ADDR_MONTH, 8'h1F);
      wr(rtc_pkg::ADDR_FLAGS, 8'hB8);
      rd("flags_rsvd", rtc_pkg::ADDR_FLAGS, 8'h00);
   endtask

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      t_reset();
      t_trim();
      t_pin();
      t_wdog();
      t_rollover();
      t_calendar();
      t_snapshot();
      t_reserved();
      complete_run();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
